// [core/ccr_pkg.sv]
// Package of offsets, field layouts and reset values for the channel config bank.
package ccr_pkg;
  // Register offsets on the control port.
  localparam logic [7:0] CCR_OFS_INPUT_SETUP = 8'h3C;
  localparam logic [7:0] CCR_OFS_GAIN = 8'h3D;
  localparam logic [7:0] CCR_OFS_VOLUME = 8'h3E;
  localparam logic [7:0] CCR_OFS_GAIN_TRIM = 8'h3F;
  localparam logic [7:0] CCR_OFS_PHASE_TRIM = 8'h40;
  localparam int CCR_NUM_REGS = 5;

  // Reset values.
  localparam logic [7:0] CCR_RST_INPUT_SETUP = 8'h00;
  localparam logic [7:0] CCR_RST_GAIN = 8'h00;
  localparam logic [7:0] CCR_RST_VOLUME = 8'hC9;
  localparam logic [7:0] CCR_RST_GAIN_TRIM = 8'h80;
  localparam logic [7:0] CCR_RST_PHASE_TRIM = 8'h00;

  // Writable bits per register; others are reserved and read zero.
  localparam logic [7:0] CCR_WMASK_INPUT_SETUP = 8'hFD;
  localparam logic [7:0] CCR_WMASK_GAIN_TRIM = 8'hF0;
  localparam logic [7:0] CCR_WMASK_FULL = 8'hFF;

  // Field positions.
  localparam int CCR_POS_KIND = 7;
  localparam int CCR_POS_SRC = 5;
  localparam int CCR_POS_COUPLING = 4;
  localparam int CCR_POS_IMP = 2;
  localparam int CCR_POS_RGC_EN = 0;
  localparam int CCR_POS_GAIN = 1;
  localparam int CCR_POS_NEG = 0;
  localparam int CCR_POS_TRIM = 4;

  // Gain code limit and field values.
  localparam logic [6:0] CCR_GAIN_MAX = 7'h54;
  localparam logic [3:0] CCR_TRIM_UNITY = 4'h8;

  // Input source codes.
  typedef enum logic [1:0] {
    CCR_SRC_ANA_DIFF = 2'h0,
    CCR_SRC_ANA_SE = 2'h1,
    CCR_SRC_DMIC = 2'h2,
    CCR_SRC_RSVD = 2'h3
  } ccr_src_e;

  // Input impedance codes.
  typedef enum logic [1:0] {
    CCR_IMP_2K5 = 2'h0,
    CCR_IMP_10K = 2'h1,
    CCR_IMP_20K = 2'h2,
    CCR_IMP_RSVD = 2'h3
  } ccr_imp_e;

  // Control port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_req_s;

  // Decoded settings handed to the channel datapath.
  typedef struct packed {
    logic line_input;
    ccr_src_e input_source_select;
    logic coupling_select;
    ccr_imp_e impedance_select;
    logic range_gain_ctrl_enable;
    logic [6:0] analog_gain_code;
    logic gain_negative_flag;
    logic [7:0] volume_code;
    logic [3:0] gain_trim_code;
    logic [7:0] phase_trim_code;
    logic analog_path;
    logic dmic_path;
    logic volume_muted;
  } ccr_cfg_s;
endpackage : ccr_pkg

// [core/ccr_reg8.sv]
// One 8-bit configuration register with write mask and reset value.
`timescale 1ns/1ps
`default_nettype none
module ccr_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Write port.
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  // Stored value.
  output logic [7:0] q_o
);
  typedef struct packed {
    logic [7:0] val;
  } ccr_reg_s;

  ccr_reg_s st_q;
  ccr_reg_s st_d;

  // Masked bits never store, so reserved bits always read zero.
  always_comb begin
    st_d = st_q;
    if (we_i) begin
      st_d.val = wdata_i & WMASK;
    end
  end

  // Reset restores the documented value.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '{val: RST_VAL & WMASK};
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.val;
endmodule : ccr_reg8
`default_nettype wire

// [core/ccr_chan_cfg.sv]
// Channel one configuration register bank with decoded settings outputs.
// Functional notes
// RULE_01 - Bit 7 of input setup picks microphone input at 0 and line at 1, reset 0.
// RULE_02 - Bits 6-5 pick differential, single-ended or digital mic; code 3 is reserved.
// RULE_03 - Software must set the general pins up as mic data and clock for the digital mic.
// RULE_04 - Bit 4 picks AC coupling at 0 and DC at 1, meaningful only for analog sources.
// RULE_05 - Bits 3-2 pick 2.5, 10 or 20 kilohm impedance; code 3 is reserved.
// RULE_06 - Reserved bits read zero and software writes only zero to them.
// RULE_07 - Bit 0 of input setup enables range enhancer, level control or compressor.
// RULE_08 - Gain bits 7-1 give 0 to 42 dB in half-dB steps, reset zero.
// RULE_09 - Software must never program gain codes 85 to 127.
// RULE_10 - Gain bit 0 makes the gain negative down to -11 dB, only at 10 or 20 kilohm.
// RULE_11 - Volume code 0 mutes, 1 is -100 dB, 201 is 0 dB, 255 is 27 dB.
// RULE_12 - Volume resets to 0xC9, unity.
// RULE_13 - Trim bits 7-4 give -0.8 dB at 0 through 0 dB at 8 to 0.7 dB at 15.
// RULE_14 - Trim resets to code 8, no trim.
// RULE_15 - Phase trim delays the channel by 0 to 255 modulator clock cycles.
// RULE_16 - Fields reset to documented values, hold writes, and read back as stored.
`timescale 1ns/1ps
`default_nettype none
module ccr_chan_cfg (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Control port from the serial control decoder.
  input wire ccr_pkg::ccr_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic hit_o,
  // Settings to the channel datapath.
  output ccr_pkg::ccr_cfg_s cfg_o
);
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    ccr_pkg::ccr_cfg_s cfg;
  } ccr_top_s;

  localparam int NR = ccr_pkg::CCR_NUM_REGS;
  localparam logic [7:0] OFS [NR] = '{
    ccr_pkg::CCR_OFS_INPUT_SETUP, ccr_pkg::CCR_OFS_GAIN,
    ccr_pkg::CCR_OFS_VOLUME, ccr_pkg::CCR_OFS_GAIN_TRIM,
    ccr_pkg::CCR_OFS_PHASE_TRIM};
  localparam logic [7:0] RST [NR] = '{
    ccr_pkg::CCR_RST_INPUT_SETUP, ccr_pkg::CCR_RST_GAIN,
    ccr_pkg::CCR_RST_VOLUME, ccr_pkg::CCR_RST_GAIN_TRIM,
    ccr_pkg::CCR_RST_PHASE_TRIM};
  localparam logic [7:0] MSK [NR] = '{
    ccr_pkg::CCR_WMASK_INPUT_SETUP, ccr_pkg::CCR_WMASK_FULL,
    ccr_pkg::CCR_WMASK_FULL, ccr_pkg::CCR_WMASK_GAIN_TRIM,
    ccr_pkg::CCR_WMASK_FULL};

  logic [7:0] regs [NR];
  logic [NR-1:0] sel;
  ccr_top_s st_q;
  ccr_top_s st_d;

  // One storage register per mapped offset.
  for (genvar i = 0; i < NR; i++) begin : g_reg
    assign sel[i] = (req_i.addr == OFS[i]);
    ccr_reg8 #(
      .RST_VAL(RST[i]),
      .WMASK(MSK[i])
    ) u_reg (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .we_i(req_i.wr && sel[i]), // RULE_16
      .wdata_i(req_i.wdata),
      .q_o(regs[i])
    );
  end

  // Read mux and decode of the stored fields into datapath settings.
  // Reserved source and impedance codes are stored as written; the datapath
  // treats them as undefined, which keeps read-back faithful to software.
  always_comb begin
    logic [7:0] s0;
    logic [7:0] g;
    s0 = regs[0];
    g = regs[1];
    st_d = st_q;
    st_d.rvalid = req_i.rd;
    st_d.hit = |sel;
    if (req_i.rd) begin
      st_d.rdata = 8'h00; // Unmapped reads return zero.
      for (int k = 0; k < NR; k++) begin
        if (sel[k]) begin
          st_d.rdata = regs[k]; // RULE_16 RULE_06
        end
      end
    end
    st_d.cfg.line_input = s0[ccr_pkg::CCR_POS_KIND]; // RULE_01
    st_d.cfg.input_source_select =
      ccr_pkg::ccr_src_e'(s0[ccr_pkg::CCR_POS_SRC +: 2]); // RULE_02
    st_d.cfg.analog_path = (s0[ccr_pkg::CCR_POS_SRC +: 2] ==
      ccr_pkg::CCR_SRC_ANA_DIFF) || (s0[ccr_pkg::CCR_POS_SRC +: 2] ==
      ccr_pkg::CCR_SRC_ANA_SE);
    st_d.cfg.dmic_path =
      (s0[ccr_pkg::CCR_POS_SRC +: 2] == ccr_pkg::CCR_SRC_DMIC);
    // Coupling and impedance only steer the analog front end.
    st_d.cfg.coupling_select = s0[ccr_pkg::CCR_POS_COUPLING] &&
      st_d.cfg.analog_path; // RULE_04
    st_d.cfg.impedance_select = st_d.cfg.analog_path ?
      ccr_pkg::ccr_imp_e'(s0[ccr_pkg::CCR_POS_IMP +: 2]) :
      ccr_pkg::CCR_IMP_2K5; // RULE_05
    st_d.cfg.range_gain_ctrl_enable = s0[ccr_pkg::CCR_POS_RGC_EN]; // RULE_07
    st_d.cfg.analog_gain_code = g[ccr_pkg::CCR_POS_GAIN +: 7]; // RULE_08
    // Negative gain is only honoured at the higher impedances. The decoded
    // impedance is used, so a digital mic source never turns the gain negative.
    st_d.cfg.gain_negative_flag = g[ccr_pkg::CCR_POS_NEG] &&
      (st_d.cfg.impedance_select == ccr_pkg::CCR_IMP_10K ||
       st_d.cfg.impedance_select == ccr_pkg::CCR_IMP_20K); // RULE_10
    st_d.cfg.volume_code = regs[2]; // RULE_11 RULE_12
    st_d.cfg.volume_muted = (regs[2] == 8'h00); // RULE_11
    st_d.cfg.gain_trim_code = regs[3][ccr_pkg::CCR_POS_TRIM +: 4]; // RULE_13
    st_d.cfg.phase_trim_code = regs[4]; // RULE_15
  end

  // Output state register; settings track storage one cycle later.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      st_q.cfg.volume_code <= ccr_pkg::CCR_RST_VOLUME; // RULE_12
      st_q.cfg.gain_trim_code <= ccr_pkg::CCR_TRIM_UNITY; // RULE_14
      st_q.cfg.analog_path <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign rvalid_o = st_q.rvalid;
  assign hit_o = st_q.hit;
  assign cfg_o = st_q.cfg;

  // Assertions.
  // Reserved storage bits can never hold a one, whatever software writes.
  a_rsv_bits_zero: assert property ( // RULE_06
    @(posedge core_clk_i) disable iff (!nrst_i)
    (regs[0][1] == 1'b0) && (regs[3][3:0] == 4'h0))
    else $error("Reserved bits are not zero.");
  // A write followed at once by a read of the same place returns the write.
  a_write_readback: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_VOLUME ##1
    req_i.rd && !req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_VOLUME
    |=> rdata_o == $past(req_i.wdata, 2))
    else $error("Volume read-back differs from write.");
  // The volume setting trails its storage by exactly one cycle.
  a_vol_follows: assert property ( // RULE_11
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 cfg_o.volume_code == $past(regs[2]))
    else $error("Volume output does not follow register.");
  // Mute is code zero and nothing else.
  a_mute_code: assert property ( // RULE_11
    @(posedge core_clk_i) disable iff (!nrst_i)
    cfg_o.volume_muted == (cfg_o.volume_code == 8'h00))
    else $error("Mute flag disagrees with volume code.");
  // Negative gain would overdrive the 2.5 kilohm input, so it is barred there.
  a_neg_gain_imp: assert property ( // RULE_10
    @(posedge core_clk_i) disable iff (!nrst_i)
    cfg_o.gain_negative_flag |-> cfg_o.impedance_select inside
    {ccr_pkg::CCR_IMP_10K, ccr_pkg::CCR_IMP_20K})
    else $error("Negative gain at low impedance.");
  // DC coupling never reaches the front end while a digital mic is chosen.
  a_dc_analog_only: assert property ( // RULE_04
    @(posedge core_clk_i) disable iff (!nrst_i)
    cfg_o.coupling_select |-> cfg_o.analog_path)
    else $error("DC coupling outside analog path.");
  // Each field reaches the datapath two edges after its write.
  a_gain_follows: assert property ( // RULE_08
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_GAIN |-> ##2
    cfg_o.analog_gain_code == $past(req_i.wdata[7:1], 2))
    else $error("Gain code not applied after write.");
  a_trim_follows: assert property ( // RULE_13
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_GAIN_TRIM |-> ##2
    cfg_o.gain_trim_code == $past(req_i.wdata[7:4], 2))
    else $error("Trim code not applied after write.");
  a_kind_follows: assert property ( // RULE_01
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_INPUT_SETUP |-> ##2
    cfg_o.line_input == $past(req_i.wdata[7], 2) &&
    cfg_o.range_gain_ctrl_enable == $past(req_i.wdata[0], 2))
    else $error("Input kind not applied after write.");
  a_phase_follows: assert property ( // RULE_15
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_PHASE_TRIM |-> ##2
    cfg_o.phase_trim_code == $past(req_i.wdata, 2))
    else $error("Phase trim not applied after write.");
  a_src_follows: assert property ( // RULE_02
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && req_i.addr == ccr_pkg::CCR_OFS_INPUT_SETUP |-> ##2
    cfg_o.input_source_select == $past(req_i.wdata[6:5], 2))
    else $error("Input source not applied after write.");
  // The path flags agree with the source code; the reserved code sets neither.
  a_path_decode: assert property ( // RULE_02
    @(posedge core_clk_i) disable iff (!nrst_i)
    cfg_o.analog_path == (cfg_o.input_source_select inside
    {ccr_pkg::CCR_SRC_ANA_DIFF, ccr_pkg::CCR_SRC_ANA_SE}) &&
    cfg_o.dmic_path == (cfg_o.input_source_select == ccr_pkg::CCR_SRC_DMIC))
    else $error("Path flags disagree with source.");
  // Impedance only steers the analog front end and idles at its lowest code.
  a_imp_forced: assert property ( // RULE_05
    @(posedge core_clk_i) disable iff (!nrst_i)
    !cfg_o.analog_path |-> cfg_o.impedance_select == ccr_pkg::CCR_IMP_2K5)
    else $error("Impedance set outside analog path.");
  // Every read is answered by one valid pulse, one cycle later.
  a_read_pulse: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 rvalid_o == $past(req_i.rd))
    else $error("Read answer pulse misplaced.");
  // Unmapped reads answer zero without a hit, so software sees no alias.
  a_unmapped_read: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && !(|sel) |=> rdata_o == 8'h00 && !hit_o)
    else $error("Unmapped read returned data.");
  // The first edge after reset still shows the documented settings.
  a_reset_values: assert property ( // RULE_14
    @(posedge core_clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> cfg_o.volume_code == ccr_pkg::CCR_RST_VOLUME &&
    cfg_o.gain_trim_code == ccr_pkg::CCR_TRIM_UNITY &&
    cfg_o.analog_path && !rvalid_o)
    else $error("Settings wrong after reset.");
endmodule : ccr_chan_cfg
`default_nettype wire

// [test/tb_ccr_chan_cfg.sv]
// Self-checking bench for the channel one configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_ccr_chan_cfg;
  localparam logic [7:0] OFS [5] = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40};
  localparam logic [7:0] RST [5] = '{8'h00, 8'h00, 8'hC9, 8'h80, 8'h00};
  localparam logic [7:0] MSK [5] = '{8'hFD, 8'hFF, 8'hFF, 8'hF0, 8'hFF};
  localparam logic [7:0] VOL [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
  logic core_clk_i;
  logic nrst_i;
  ccr_pkg::ccr_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic hit;
  ccr_pkg::ccr_cfg_s cfg;
  logic [8:0] expq[$];
  logic [31:0] seed;
  int n_mismatch;
  int n_compared;

  ccr_chan_cfg dut (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .req_i(req),
    .rdata_o(rdata),
    .rvalid_o(rvalid),
    .hit_o(hit),
    .cfg_o(cfg)
  );

  // Free-running 100 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Compares one value; the wide ports let every field share this task.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen,
               exp);
    end
  endtask : chk

  // Xorshift generator, so a run always repeats the same traffic.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Presents one request for one cycle; a read notes its expected answer.
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d, input logic [8:0] e);
    @(posedge core_clk_i);
    #1;
    req = '{wr: w, rd: r, addr: a, wdata: d};
    if (r) expq.push_back(e);
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d, 9'h000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    op(1'b0, 1'b1, a, 8'h00, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00, 9'h000);
  endtask : idle

  // Holds reset for eight cycles and releases it just after an edge.
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    nrst_i = 1'b1;
  endtask : do_reset

  // Reads every register and expects its reset value.
  task automatic read_resets();
    chk(cfg.volume_code, 8'hC9, "volume out");
    chk(cfg.gain_trim_code, 4'h8, "trim out");
    for (int k = 0; k < 5; k++) rd(OFS[k], {1'b1, RST[k]});
    idle(3);
  endtask : read_resets

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Each answer pulse retires the oldest noted read, hit flag included.
  initial begin
    forever begin
      @(posedge core_clk_i);
      #2;
      if (rvalid === 1'b1) begin
        if (expq.size() == 0) chk(16'h1, 16'h0, "spare answer");
        else chk({hit, rdata}, expq.pop_front(), "read");
      end
    end
  end

  // A hang is cut short long after the 192 cycles the tests need.
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence of tests.
  initial begin
    int j;
    logic [7:0] v;
    n_mismatch = 0;
    n_compared = 0;
    seed = 32'h2;
    req = '0;
    do_reset();
    read_resets();
    $display("test reset values done");
    // Random back-to-back write and read, reserved bits set at random.
    for (int k = 0; k < 40; k++) begin
      j = int'(rnd() % 32'd5);
      v = 8'(rnd());
      if (j == 1) v[7:1] = v[7:1] % 7'd85;
      wr(OFS[j], v);
      rd(OFS[j], {1'b1, v & MSK[j]});
    end
    // Same-cycle write and read returns the old value.
    wr(8'h40, 8'h11);
    op(1'b1, 1'b1, 8'h40, 8'h5A, 9'h111);
    rd(8'h40, 9'h15A);
    // Unmapped places neither store nor answer with a hit.
    wr(8'h41, 8'hAA);
    wr(8'h3B, 8'hAA);
    rd(8'h41, 9'h000);
    rd(8'h3B, 9'h000);
    rd(8'h40, 9'h15A);
    idle(3);
    $display("test readback done");
    // Every source with every impedance, gain 84 and negative.
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 3; i++) begin
        // Pin setup for the digital mic lies outside this bank.
        wr(8'h3C, {1'b1, 2'(s), 1'b1, 2'(i), 2'b01});
        wr(8'h3D, 8'hA9);
        idle(3);
        chk({cfg.line_input, cfg.range_gain_ctrl_enable,
             cfg.analog_gain_code}, 9'h1D4, "kind gain");
        chk({cfg.input_source_select, cfg.analog_path, cfg.dmic_path},
            {2'(s), s != 2, s == 2}, "source");
        chk({cfg.coupling_select, cfg.impedance_select},
            (s == 2) ? 3'h0 : {1'b1, 2'(i)}, "coupling");
        chk(cfg.gain_negative_flag, s != 2 && i != 0, "sign");
      end
    end
    $display("test decode done");
    // Volume, trim and phase codes at their end points.
    for (int k = 0; k < 4; k++) begin
      wr(8'h3E, VOL[k]);
      wr(8'h3F, VOL[k]);
      wr(8'h40, VOL[k]);
      idle(3);
      chk(cfg.volume_code, VOL[k], "volume");
      chk(cfg.volume_muted, VOL[k] == 8'h00, "mute");
      chk(cfg.gain_trim_code, VOL[k][7:4], "trim");
      chk(cfg.phase_trim_code, VOL[k], "phase");
    end
    $display("test codes done");
    // A second reset in mid-run brings every value back.
    do_reset();
    read_resets();
    $display("test second reset done");
    chk(16'(expq.size()), 16'h0, "reads left unanswered");
    tally_and_finish();
  end
endmodule : tb_ccr_chan_cfg
`default_nettype wire
